// ===== src/bit_rate_gen.sv
// Bit rate generator: prescaler plus reloading divider.
`timescale 1ns/10ps
`include "serial_status_params.svh"

module bit_rate_gen (
  input wire logic sys_clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire serial_status_pkg::prescale_t prescale_sel, // Clock-select bits.
  input wire logic [7:0] divisor, // Bit rate divisor value N.
  output logic rate_tick // One pulse per N+1 prescaled ticks.
);

  logic [`PRESCALE_WIDTH-1:0] pre_q;
  logic [7:0] count_q;
  logic pre_tick;
  logic tick_q;

  // Returns high when the prescaler has just reached the chosen division.
  function automatic logic prescale_hit(serial_status_pkg::prescale_t sel,
                                        logic [`PRESCALE_WIDTH-1:0] cnt);
    logic hit;
    hit = 1'b1;
    unique case (sel)
      serial_status_pkg::PRE_DIV1: hit = 1'b1;
      serial_status_pkg::PRE_DIV4: hit = (cnt[1:0] == 2'h3);
      serial_status_pkg::PRE_DIV16: hit = (cnt[3:0] == 4'hF);
      serial_status_pkg::PRE_DIV64: hit = (cnt == 6'h3F);
    endcase
    return hit;
  endfunction

  // Free-running prescaler gives system clock divided by 1, 4, 16 or 64.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 6'h01;
    end
  end

  assign pre_tick = prescale_hit(prescale_sel, pre_q);

  // Divider counts down and reloads from the divisor, so a new value takes
  // effect at the next reload rather than cutting the current bit short.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= 1'b0;
      if (pre_tick) begin
        if (count_q == 8'h00) begin
          count_q <= divisor;
          tick_q <= 1'b1;
        end else begin
          count_q <= count_q - 8'h01;
        end
      end
    end
  end

  assign rate_tick = tick_q;

  // A pulse follows a prescaled tick that found the counter empty.
  reload_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (pre_tick && count_q == 8'h00) |=> (rate_tick && count_q == $past(divisor)))
    else $error("Divider reload did not pulse.");

endmodule

// ===== src/serial_status.sv
// Serial unit status flags, multiprocessor bits and bit rate register with AXI4-Lite access.
`timescale 1ns/10ps
`include "serial_status_params.svh"

module serial_status (
  input wire logic sys_clk, // System clock, 10 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic lowpower_entry, // High while a low-power mode is entered.
  input wire logic [7:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [7:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic rx_done, // Receive shifter finished a character.
  input wire logic [7:0] rx_data, // Received character.
  input wire logic rx_parity_bad, // Character failed its parity check.
  input wire logic rx_mpb, // Multiprocessor bit of the character.
  input wire logic tx_load, // Transmit shifter took the holding register.
  input wire logic tx_last_bit, // Last bit of a character left the shifter.
  output logic [7:0] tx_data, // Transmit holding register.
  output logic tx_mpb, // Multiprocessor bit to append.
  output logic rx_run, // Reception allowed.
  output logic tx_run, // Transmission allowed.
  output logic rate_tick, // Bit rate timing pulse.
  output logic irq // Level interrupt.
);

  logic [7:0] bit_rate_q, mode_q, control_q, rx_hold_q;
  logic tx_empty_q, rx_full_q, parity_q, tx_end_q, mpb_rx_q, mpb_tx_q;
  logic seen_empty_q, seen_full_q, seen_parity_q;
  logic [2:0] irq_mask_q, irq_stat_q, irq_set, irq_clr;
  logic aw_have_q, w_have_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q, rdata_q;
  logic [3:0] w_strb_q;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic wr_fire, rd_fire, wr_lane;
  logic [7:0] wbyte;
  logic rx_en, tx_en, mp_en, sync_mode;
  logic rx_take, empty_clr, full_clr, parity_clr, tx_hold_wr, stat_rd, rx_hold_rd;
  logic set_full, set_parity, set_end;

  // Returns high when the address is one of the mapped registers.
  function automatic logic addr_mapped(logic [7:0] a);
    return a == `BIT_RATE_OFF || a == `MODE_OFF || a == `CONTROL_OFF ||
           a == `TX_HOLD_OFF || a == `STATUS_OFF || a == `RX_HOLD_OFF ||
           a == `IRQ_MASK_OFF || a == `IRQ_STATUS_OFF;
  endfunction

  assign rx_en = control_q[`CTRL_RX_EN];
  assign tx_en = control_q[`CTRL_TX_EN];
  assign mp_en = mode_q[`MODE_MP_EN];
  assign sync_mode = mode_q[`MODE_SYNC];

  // Address and data are caught separately so the master may send either first.
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign wr_lane = w_strb_q[0];
  assign wbyte = w_data_q[7:0];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // Write response, one cycle after both halves are present.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= addr_mapped(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Read channel answers one cycle after the address is taken.
  assign s_axi_arready = !rvalid_q;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rresp_q <= `RESP_OKAY;
      rdata_q <= '0;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q <= addr_mapped({s_axi_araddr[7:2], 2'b00}) ? `RESP_OKAY : `RESP_SLVERR;
      unique case ({s_axi_araddr[7:2], 2'b00})
        `BIT_RATE_OFF: rdata_q <= {24'h000000, bit_rate_q};
        `MODE_OFF: rdata_q <= {24'h000000, mode_q};
        `CONTROL_OFF: rdata_q <= {24'h000000, control_q};
        `TX_HOLD_OFF: rdata_q <= {24'h000000, tx_data};
        `STATUS_OFF: rdata_q <= {24'h000000, tx_empty_q, rx_full_q, 2'b00, parity_q,
                                 tx_end_q, mpb_rx_q, mpb_tx_q};
        `RX_HOLD_OFF: rdata_q <= {24'h000000, rx_hold_q};
        `IRQ_MASK_OFF: rdata_q <= {29'h0000000, irq_mask_q};
        `IRQ_STATUS_OFF: rdata_q <= {29'h0000000, irq_stat_q};
        default: rdata_q <= '0;
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // Side effects of accesses on the flags.
  assign stat_rd = rd_fire && ({s_axi_araddr[7:2], 2'b00} == `STATUS_OFF);
  assign rx_hold_rd = rd_fire && ({s_axi_araddr[7:2], 2'b00} == `RX_HOLD_OFF);
  assign tx_hold_wr = wr_fire && wr_lane && aw_addr_q == `TX_HOLD_OFF;
  assign empty_clr = wr_fire && wr_lane && aw_addr_q == `STATUS_OFF &&
                     !wbyte[`ST_TX_EMPTY] && seen_empty_q;
  assign full_clr = (wr_fire && wr_lane && aw_addr_q == `STATUS_OFF &&
                     !wbyte[`ST_RX_FULL] && seen_full_q) || rx_hold_rd;
  assign parity_clr = wr_fire && wr_lane && aw_addr_q == `STATUS_OFF &&
                      !wbyte[`ST_PARITY] && seen_parity_q;

  // A flag only counts as read at one once a status read saw it set.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_empty_q <= 1'b0;
      seen_full_q <= 1'b0;
      seen_parity_q <= 1'b0;
    end else begin
      if (stat_rd) begin
        seen_empty_q <= tx_empty_q;
        seen_full_q <= rx_full_q;
        seen_parity_q <= parity_q;
      end else if (wr_fire && aw_addr_q == `STATUS_OFF) begin
        seen_empty_q <= 1'b0;
        seen_full_q <= 1'b0;
        seen_parity_q <= 1'b0;
      end
    end
  end

  // Plain software registers; the divisor also reloads on low-power entry.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_rate_q <= `BIT_RATE_RESET;
      mode_q <= '0;
      control_q <= '0;
      tx_data <= '0;
      irq_mask_q <= '0;
      mpb_tx_q <= 1'b0;
    end else begin
      if (lowpower_entry) begin
        bit_rate_q <= `BIT_RATE_RESET;
      end else if (wr_fire && wr_lane && aw_addr_q == `BIT_RATE_OFF) begin
        bit_rate_q <= wbyte;
      end
      if (wr_fire && wr_lane && aw_addr_q == `MODE_OFF) begin
        mode_q <= wbyte;
      end
      if (wr_fire && wr_lane && aw_addr_q == `CONTROL_OFF) begin
        control_q <= wbyte;
      end
      if (tx_hold_wr) begin
        tx_data <= wbyte;
      end
      if (wr_fire && wr_lane && aw_addr_q == `IRQ_MASK_OFF) begin
        irq_mask_q <= wbyte[2:0];
      end
      if (wr_fire && wr_lane && aw_addr_q == `STATUS_OFF) begin
        mpb_tx_q <= wbyte[`ST_MPB_TX];
      end
    end
  end

  // Receive side. With the receiver off nothing is taken, so flags change only by clearing.
  assign rx_take = rx_done && rx_en && !parity_q;
  assign set_full = rx_take && !rx_parity_bad;
  assign set_parity = rx_take && rx_parity_bad;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_hold_q <= '0;
      rx_full_q <= 1'b0;
      parity_q <= 1'b0;
      mpb_rx_q <= 1'b0;
    end else begin
      if (rx_take) begin
        rx_hold_q <= rx_data;
      end
      if (rx_take && mp_en && !sync_mode) begin
        mpb_rx_q <= rx_mpb;
      end
      // Setting beats a clear arriving in the same cycle.
      if (set_full) begin
        rx_full_q <= 1'b1;
      end else if (full_clr) begin
        rx_full_q <= 1'b0;
      end
      if (set_parity) begin
        parity_q <= 1'b1;
      end else if (parity_clr) begin
        parity_q <= 1'b0;
      end
    end
  end

  // Transmit side flags; both rise and stay up while the transmitter is off.
  assign set_end = !tx_en || (tx_last_bit && tx_empty_q);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_empty_q <= 1'b1;
      tx_end_q <= 1'b1;
    end else begin
      if (!tx_en || tx_load) begin
        tx_empty_q <= 1'b1;
      end else if (empty_clr || tx_hold_wr) begin
        tx_empty_q <= 1'b0;
      end
      if (set_end) begin
        tx_end_q <= 1'b1;
      end else if (empty_clr || tx_hold_wr) begin
        tx_end_q <= 1'b0;
      end
    end
  end

  // A parity error stalls the receiver, and in synchronous mode both sides.
  assign rx_run = rx_en && !parity_q;
  assign tx_run = tx_en && !(sync_mode && parity_q);
  assign tx_mpb = mpb_tx_q && mp_en && !sync_mode && tx_en;

  // Interrupt status is sticky, cleared by writing one; set wins over a clear.
  assign irq_set = {set_end && !tx_end_q, set_parity, set_full};
  assign irq_clr = wbyte[2:0] & {3{wr_fire && wr_lane && aw_addr_q == `IRQ_STATUS_OFF}};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= irq_set | (irq_stat_q & ~irq_clr);
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  // The divider sees the async rate as clock/(4^n*(N+1)); the shifter takes
  // the remaining factor of 64 as oversampling.
  bit_rate_gen u_rate (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .prescale_sel(serial_status_pkg::prescale_t'(mode_q[`MODE_CKS_HI:`MODE_CKS_LO])),
    .divisor(bit_rate_q),
    .rate_tick(rate_tick)
  );

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  rate_lowpower_a: assert property (lowpower_entry |=> bit_rate_q == 8'hFF)
    else $error("Divisor not reloaded on low power.");
  parity_hold_a: assert property (!rx_en && !parity_clr |=> $stable(parity_q))
    else $error("Parity flag moved with receiver off.");
  parity_load_a: assert property (
    rx_take && rx_parity_bad |=> rx_hold_q == $past(rx_data) && !$rose(rx_full_q))
    else $error("Parity-bad character handled wrongly.");
  parity_halt_a: assert property (parity_q |-> !rx_run && (!sync_mode || !tx_run))
    else $error("Transfer continued with parity error.");
  end_clear_a: assert property (tx_hold_wr && tx_en && !tx_last_bit |=> !tx_end_q)
    else $error("Transmit end not cleared by write.");
  end_disable_a: assert property (!tx_en |=> tx_end_q && tx_empty_q)
    else $error("Transmit end low with transmitter off.");
  end_last_a: assert property (tx_last_bit && tx_empty_q |=> tx_end_q)
    else $error("Transmit end not set at last bit.");
  mpb_capture_a: assert property (
    rx_take && mp_en && !sync_mode |=> mpb_rx_q == $past(rx_mpb))
    else $error("Multiprocessor bit not captured.");
  mpb_hold_a: assert property (!rx_en |=> $stable(mpb_rx_q))
    else $error("Multiprocessor bit moved with receiver off.");
  mpb_ignore_a: assert property (sync_mode || !mp_en || !tx_en |-> !tx_mpb)
    else $error("Multiprocessor bit sent when not applicable.");
  parity_clear_a: assert property (parity_clr && !set_parity |=> !parity_q)
    else $error("Parity flag not cleared after read.");

endmodule

// ===== src/serial_status_params.svh
// Register offsets, field positions, reset value, prescaler width and response codes for the serial status block.
`ifndef SERIAL_STATUS_PARAMS_SVH
`define SERIAL_STATUS_PARAMS_SVH

`define BIT_RATE_OFF 8'h00
`define MODE_OFF 8'h04
`define CONTROL_OFF 8'h08
`define TX_HOLD_OFF 8'h0C
`define STATUS_OFF 8'h10
`define RX_HOLD_OFF 8'h14
`define IRQ_MASK_OFF 8'h18
`define IRQ_STATUS_OFF 8'h1C

`define BIT_RATE_RESET 8'hFF
`define MODE_CKS_LO 0
`define MODE_CKS_HI 1
`define MODE_MP_EN 2
`define MODE_SYNC 7
`define CTRL_RX_EN 4
`define CTRL_TX_EN 5
`define ST_TX_EMPTY 7
`define ST_RX_FULL 6
`define ST_PARITY 3
`define ST_TX_END 2
`define ST_MPB_RX 1
`define ST_MPB_TX 0
`define IRQ_RX_FULL 0
`define IRQ_PARITY 1
`define IRQ_TX_END 2

`define PRESCALE_WIDTH 6
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== src/serial_status_pkg.sv
// Types shared by the serial status block and its bit rate generator.
package serial_status_pkg;

  // Prescaler choice taken from the two clock-select bits.
  typedef enum logic [1:0] {
    PRE_DIV1 = 2'b00,
    PRE_DIV4 = 2'b01,
    PRE_DIV16 = 2'b10,
    PRE_DIV64 = 2'b11
  } prescale_t;

endpackage

// ===== verification/serial_station_model.sv
// Remote serial station model that feeds received characters and drains the transmitter.
`timescale 1ns/10ps

module serial_station_model (
  input wire logic sys_clk, // System clock.
  input wire logic [7:0] tx_data, // Character offered by the transmitter.
  input wire logic tx_mpb, // Multiprocessor bit offered with it.
  output logic rx_done, // Character finished pulse.
  output logic [7:0] rx_data, // Received character.
  output logic rx_parity_bad, // Parity check failed.
  output logic rx_mpb, // Received multiprocessor bit.
  output logic tx_load, // Shifter took the holding register.
  output logic tx_last_bit // Last bit left the shifter.
);
  logic [7:0] sent_data = 8'h00; // Last character taken from the transmitter.
  logic sent_mpb = 1'b0; // Multiprocessor bit sent with it.

  // Lines start idle at time zero.
  initial begin
    rx_done = 1'b0;
    rx_data = 8'h00;
    rx_parity_bad = 1'b0;
    rx_mpb = 1'b0;
    tx_load = 1'b0;
    tx_last_bit = 1'b0;
  end

  // One received character; afterwards the lines carry the inverse so stale values cannot pass.
  task automatic deliver(input logic [7:0] d, input logic bad, input logic mpb);
    rx_done <= 1'b1;
    rx_data <= d;
    rx_parity_bad <= bad;
    rx_mpb <= mpb;
    @(posedge sys_clk);
    rx_done <= 1'b0;
    rx_data <= ~d;
    rx_parity_bad <= ~bad;
    rx_mpb <= ~mpb;
    @(posedge sys_clk);
  endtask

  // Takes the holding register, shifts for a number of clock cycles, then reports the last bit.
  task automatic shift_out(input int bits);
    tx_load <= 1'b1;
    @(posedge sys_clk);
    sent_data = tx_data;
    sent_mpb = tx_mpb;
    tx_load <= 1'b0;
    repeat (bits) @(posedge sys_clk);
    tx_last_bit <= 1'b1;
    @(posedge sys_clk);
    tx_last_bit <= 1'b0;
    @(posedge sys_clk);
  endtask
endmodule

// ===== verification/tb_top.sv
// Self-checking bench for the serial status block and its remote station model.
`timescale 1ns/10ps
`include "serial_status_params.svh"

module tb_top;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic lowpower_entry = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic s_axi_wvalid = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic rx_done, rx_parity_bad, rx_mpb, tx_load, tx_last_bit, tx_mpb;
  logic rx_run, tx_run, rate_tick, irq;
  logic [7:0] rx_data, tx_data;
  logic [31:0] got;
  logic [1:0] resp;
  int failures = 0;
  int n_tests = 0;

  // The slave answers at its own pace, so the clock is the only time base.
  always #50 sys_clk = ~sys_clk;

  serial_status serial_status_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .lowpower_entry(lowpower_entry), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(1'b1), .rx_done(rx_done), .rx_data(rx_data), .rx_parity_bad(rx_parity_bad),
    .rx_mpb(rx_mpb), .tx_load(tx_load), .tx_last_bit(tx_last_bit), .tx_data(tx_data),
    .tx_mpb(tx_mpb), .rx_run(rx_run), .tx_run(tx_run), .rate_tick(rate_tick), .irq(irq));

  serial_station_model serial_station_model_inst (.sys_clk(sys_clk), .tx_data(tx_data),
    .tx_mpb(tx_mpb), .rx_done(rx_done), .rx_data(rx_data), .rx_parity_bad(rx_parity_bad),
    .rx_mpb(rx_mpb), .tx_load(tx_load), .tx_last_bit(tx_last_bit));

  // Prints the verdict and ends the run.
  task automatic complete_run;
    if (failures == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Compares one value against its expectation.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // A wait that used up its bound ends the run.
  task automatic guard(input int n, input int lim);
    if (n >= lim) begin
      failures++;
      $display("unexpected wait expected below %0d seen %0d", lim, n);
      complete_run();
    end
  endtask

  // Write: both channels offered together, each released on its own handshake.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_on, w_on;
    int n;
    aw_on = 1'b1;
    w_on = 1'b1;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while ((aw_on || w_on) && n < 50) begin
      @(posedge sys_clk);
      n++;
      if (aw_on && s_axi_awready) begin
        aw_on = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_on && s_axi_wready) begin
        w_on = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge sys_clk);
      n++;
    end while (!s_axi_bvalid && n < 50);
    resp = s_axi_bresp;
    guard(n, 50);
  endtask

  // Read: address held until taken, data taken at the edge where rvalid is seen.
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (!s_axi_arready && n < 50);
    s_axi_arvalid <= 1'b0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (!s_axi_rvalid && n < 50);
    got = s_axi_rdata;
    resp = s_axi_rresp;
    guard(n, 50);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
    rd(a);
    chk(nm, got, e);
  endtask

  // Status word laid out from its flag values.
  function automatic logic [31:0] st(logic te, logic rf, logic pe, logic tn, logic mr, logic mt);
    st = {24'h000000, te, rf, 2'b00, pe, tn, mr, mt};
  endfunction

  // Cycles between bit rate pulses for prescaler choice n and divisor v.
  function automatic int gap_of(int n, logic [7:0] v);
    gap_of = (4 ** n) * (int'(v) + 1);
  endfunction

  // Skips two pulses so a new setting has been reloaded, then times one period.
  task automatic tick_gap(output int gap);
    int n;
    n = 0;
    gap = 0;
    repeat (2) begin
      do begin
        @(posedge sys_clk);
        n++;
      end while (!rate_tick && n < 1100);
    end
    do begin
      @(posedge sys_clk);
      gap++;
    end while (!rate_tick && gap < 1100);
    guard(n, 1100);
    guard(gap, 1100);
  endtask

  initial begin
    logic [7:0] d, d2;
    int gap;
    void'($urandom(5));
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rdc(`BIT_RATE_OFF, 32'h000000FF, "divisor reset");
    rdc(`STATUS_OFF, st(1, 0, 0, 1, 0, 0), "status reset");
    rd(8'h20);
    chk("unmapped read", 32'(resp), 32'(`RESP_SLVERR));
    wr(8'h24, 32'h00000001);
    chk("unmapped write", 32'(resp), 32'(`RESP_SLVERR));
    // Divisor readback at random values, including while the generator runs.
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      wr(`BIT_RATE_OFF, {24'h000000, d});
      rdc(`BIT_RATE_OFF, {24'h000000, d}, "divisor rw");
    end
    lowpower_entry <= 1'b1;
    @(posedge sys_clk);
    lowpower_entry <= 1'b0;
    @(posedge sys_clk);
    rdc(`BIT_RATE_OFF, 32'h000000FF, "divisor low power");
    // Every prescaler choice with a small random divisor.
    for (int n = 0; n < 4; n++) begin
      d = 8'($urandom % 4);
      wr(`MODE_OFF, 32'(n));
      wr(`BIT_RATE_OFF, {24'h000000, d});
      tick_gap(gap);
      chk("tick period", 32'(gap), 32'(gap_of(n, d)));
    end
    // Reception with multiprocessor format, then a parity fault.
    wr(`MODE_OFF, 32'h00000004);
    wr(`CONTROL_OFF, 32'h00000010);
    wr(`IRQ_MASK_OFF, 32'h00000002);
    chk("rx run", 32'(rx_run), 32'h1);
    d = 8'($urandom);
    serial_station_model_inst.deliver(d, 1'b0, 1'b1);
    rdc(`STATUS_OFF, st(1, 1, 0, 1, 1, 0), "status rx good");
    rdc(`RX_HOLD_OFF, {24'h000000, d}, "rx hold good");
    d2 = 8'($urandom);
    serial_station_model_inst.deliver(d2, 1'b1, 1'b1);
    chk("irq parity", 32'(irq), 32'h1);
    chk("rx run parity", 32'(rx_run), 32'h0);
    rdc(`RX_HOLD_OFF, {24'h000000, d2}, "rx hold parity");
    rdc(`STATUS_OFF, st(1, 0, 1, 1, 1, 0), "status parity");
    serial_station_model_inst.deliver(~d2, 1'b0, 1'b0);
    rdc(`RX_HOLD_OFF, {24'h000000, d2}, "rx hold halted");
    wr(`CONTROL_OFF, 32'h00000030);
    wr(`MODE_OFF, 32'h00000084);
    chk("tx run sync parity", 32'(tx_run), 32'h0);
    wr(`MODE_OFF, 32'h00000004);
    chk("tx run async parity", 32'(tx_run), 32'h1);
    wr(`CONTROL_OFF, 32'h00000000);
    rdc(`STATUS_OFF, st(1, 0, 1, 1, 1, 0), "parity rx off");
    wr(`STATUS_OFF, 32'h00000080);
    rdc(`STATUS_OFF, st(1, 0, 0, 1, 1, 0), "parity cleared");
    serial_station_model_inst.deliver(d, 1'b0, 1'b0);
    rdc(`STATUS_OFF, st(1, 0, 0, 1, 1, 0), "mpb rx off");
    wr(`IRQ_MASK_OFF, 32'h00000000);
    chk("irq masked", 32'(irq), 32'h0);
    wr(`IRQ_MASK_OFF, 32'h00000002);
    chk("irq unmasked", 32'(irq), 32'h1);
    wr(`IRQ_STATUS_OFF, 32'h00000002);
    chk("irq cleared", 32'(irq), 32'h0);
    // Transmission and the transmit end flag.
    wr(`CONTROL_OFF, 32'h00000020);
    chk("tx run", 32'(tx_run), 32'h1);
    d = 8'($urandom);
    wr(`TX_HOLD_OFF, {24'h000000, d});
    chk("tx data", 32'(tx_data), {24'h000000, d});
    rdc(`STATUS_OFF, st(0, 0, 0, 0, 1, 0), "tx end on write");
    wr(`STATUS_OFF, 32'h00000081);
    chk("tx mpb async", 32'(tx_mpb), 32'h1);
    wr(`MODE_OFF, 32'h00000084);
    chk("tx mpb sync", 32'(tx_mpb), 32'h0);
    wr(`MODE_OFF, 32'h00000000);
    chk("tx mpb no mp", 32'(tx_mpb), 32'h0);
    wr(`MODE_OFF, 32'h00000004);
    serial_station_model_inst.shift_out(1 + $urandom % 12);
    chk("sent data", 32'(serial_station_model_inst.sent_data), {24'h000000, d});
    chk("sent mpb", 32'(serial_station_model_inst.sent_mpb), 32'h1);
    rdc(`STATUS_OFF, st(1, 0, 0, 1, 1, 1), "tx end last bit");
    wr(`STATUS_OFF, 32'h00000081);
    rdc(`STATUS_OFF, st(1, 0, 0, 1, 1, 1), "tx end read only");
    wr(`STATUS_OFF, 32'h00000001);
    rdc(`STATUS_OFF, st(0, 0, 0, 0, 1, 1), "tx end empty clear");
    wr(`CONTROL_OFF, 32'h00000000);
    rdc(`STATUS_OFF, st(1, 0, 0, 1, 1, 1), "tx end tx off");
    chk("tx mpb idle", 32'(tx_mpb), 32'h0);
    complete_run();
  end
endmodule
